// [design/arc_blink.v]
// timed blinker with optional flash groups
`timescale 1ns/1ns
`include "arc_map.vh"
module arc_blink #(
	parameter [31:0] HALF_CYC = `ARC_HALF_CYC
) (
	// clock and reset
	input  wire        clk_i,
	input  wire        reset_n_i,
	// start request
	input  wire        start_i,
	input  wire [2:0]  flashes_i,
	input  wire [31:0] dur_i,
	// lamp drive and activity
	output wire        led_o,
	output wire        busy_o
);

reg        busy_q;
reg [31:0] dur_q;
reg [31:0] tick_q;
reg [3:0]  slot_q;
reg [2:0]  flash_q;

// group: n flashes then two dark slots; n of zero is a plain blink
wire [3:0] last_slot = (flash_q == `ARC_FLASH_PLAIN) ? 4'h1 :
	{flash_q, 1'b0} + 4'h1;
wire       lit = ~slot_q[0] &&
	(flash_q == `ARC_FLASH_PLAIN || slot_q < {flash_q, 1'b0});

assign led_o  = busy_q & lit;
assign busy_o = busy_q;

always @(posedge clk_i or negedge reset_n_i) begin
	if (!reset_n_i) begin
		busy_q  <= 1'b0;
		dur_q   <= `ARC_RST_CNT;
		tick_q  <= `ARC_RST_CNT;
		slot_q  <= 4'h0;
		flash_q <= `ARC_FLASH_PLAIN;
	end else if (start_i) begin
		busy_q  <= 1'b1;
		dur_q   <= dur_i;
		tick_q  <= `ARC_RST_CNT;
		slot_q  <= 4'h0;
		flash_q <= flashes_i;
	end else if (busy_q) begin
		dur_q <= dur_q - 32'h1;
		if (dur_q <= 32'h1)
			busy_q <= 1'b0;
		if (tick_q >= HALF_CYC - 32'h1) begin
			tick_q <= `ARC_RST_CNT;
			slot_q <= (slot_q >= last_slot) ? 4'h0 : slot_q + 4'h1;
		end else begin
			tick_q <= tick_q + 32'h1;
		end
	end
end

endmodule // arc_blink

// [design/arc_debounce.v]
// button synchroniser, debouncer and press classifier
`timescale 1ns/1ns
`include "arc_map.vh"
module arc_debounce #(
	parameter [31:0] DEB_CYC   = `ARC_DEB_CYC,
	parameter [31:0] SHORT_CYC = `ARC_SHORT_CYC,
	parameter [31:0] LONG_CYC  = `ARC_LONG_CYC
) (
	// clock and reset
	input  wire        clk_i,
	input  wire        reset_n_i,
	// raw pin, low while pressed
	input  wire        button_n_i,
	// press events, one cycle each
	output reg         short_o,
	output reg         status_o,
	output reg         long_o
);

reg        s1_q;
reg        s2_q;
reg        pressed_q;
reg [31:0] deb_q;
reg [31:0] hold_q;

always @(posedge clk_i or negedge reset_n_i) begin
	if (!reset_n_i) begin
		s1_q      <= 1'b1;
		s2_q      <= 1'b1;
		pressed_q <= 1'b0;
		deb_q     <= `ARC_RST_CNT;
		hold_q    <= `ARC_RST_CNT;
		short_o   <= 1'b0;
		status_o  <= 1'b0;
		long_o    <= 1'b0;
	end else begin
		s1_q     <= button_n_i;
		s2_q     <= s1_q;
		short_o  <= 1'b0;
		status_o <= 1'b0;
		long_o   <= 1'b0;
		if (~s2_q == pressed_q) begin
			deb_q <= `ARC_RST_CNT;
		end else if (deb_q >= DEB_CYC - 32'h1) begin
			deb_q     <= `ARC_RST_CNT;
			pressed_q <= ~s2_q;
		end else begin
			deb_q <= deb_q + 32'h1;
		end
		if (pressed_q) begin
			if (hold_q < LONG_CYC)
				hold_q <= hold_q + 32'h1;
			if (hold_q == LONG_CYC - 32'h1)
				long_o <= 1'b1;
		end else begin
			hold_q <= `ARC_RST_CNT;
		end
		// classify on release; long holds already reported
		if (pressed_q && s2_q && deb_q >= DEB_CYC - 32'h1) begin
			if (hold_q < SHORT_CYC)
				short_o <= 1'b1;
			else if (hold_q < LONG_CYC)
				status_o <= 1'b1;
		end
	end
end

endmodule // arc_debounce

// [design/arc_map.vh]
// constants of the autonomous replay controller
`ifndef ARC_MAP_VH
`define ARC_MAP_VH

// clock rate in kHz, 100 MHz
`define ARC_CLK_KHZ 100000

// times in milliseconds
`define ARC_DEB_MS 10
`define ARC_SHORT_MS 1000
`define ARC_LONG_MS 5000
`define ARC_HALF_MS 250
`define ARC_RESULT_MS 4000
`define ARC_STATUS_MS 2000

// the same times in clock cycles
`define ARC_DEB_CYC (`ARC_DEB_MS * `ARC_CLK_KHZ)
`define ARC_SHORT_CYC (`ARC_SHORT_MS * `ARC_CLK_KHZ)
`define ARC_LONG_CYC (`ARC_LONG_MS * `ARC_CLK_KHZ)
`define ARC_HALF_CYC (`ARC_HALF_MS * `ARC_CLK_KHZ)
`define ARC_RESULT_CYC (`ARC_RESULT_MS * `ARC_CLK_KHZ)
`define ARC_STATUS_CYC (`ARC_STATUS_MS * `ARC_CLK_KHZ)

// host request kinds
`define ARC_KIND_EXEC 2'h0
`define ARC_KIND_SET_VT 2'h1
`define ARC_KIND_SET_REF 2'h2
`define ARC_KIND_READ_V 2'h3

// answer and reset values
`define ARC_RSP_OK 8'h00
`define ARC_RST_BYTE 8'h00
`define ARC_RST_CNT 32'h0

// flash counts of the result blink
`define ARC_FLASH_PLAIN 3'h0
`define ARC_FLASH_LOG 3'h3

`endif

// [design/arc_top.v]
// autonomous replay control: button, log record and replay, indicator
//
// Overview of operation
// - five second hold enters recording
// - recording executes and logs host commands
// - press under five seconds leaves recording, stops logging
// - short press in normal replays log
// - replay lights indicator yellow
// - blink green on success, red on failure
// - after blinking return to steady green
// - one to five second hold shows status
// - status blinks green valid, red invalid
// - supply and reference settings accepted, ignored
// - measured supply reported as both values
// - red flash count names failing action
`timescale 1ns/1ns
`include "arc_map.vh"
module arc_top #(
	parameter [31:0] DEB_CYC    = `ARC_DEB_CYC,
	parameter [31:0] SHORT_CYC  = `ARC_SHORT_CYC,
	parameter [31:0] LONG_CYC   = `ARC_LONG_CYC,
	parameter [31:0] HALF_CYC   = `ARC_HALF_CYC,
	parameter [31:0] RESULT_CYC = `ARC_RESULT_CYC,
	parameter [31:0] STATUS_CYC = `ARC_STATUS_CYC
) (
	// clock and reset
	input  wire       CLK_I,
	input  wire       RESET_N_I,
	// push button pin, low while pressed
	input  wire       BUTTON_N_I,
	// host request link
	input  wire       HOST_CMD_VALID_I,
	output wire       HOST_CMD_READY_O,
	input  wire [1:0] HOST_CMD_KIND_I,
	input  wire [7:0] HOST_CMD_DATA_I,
	output wire       HOST_RSP_VALID_O,
	output wire [7:0] HOST_RSP_DATA_O,
	// programming engine
	output wire       EXEC_VALID_O,
	input  wire       EXEC_READY_I,
	output wire [7:0] EXEC_DATA_O,
	input  wire       EXEC_DONE_I,
	input  wire       EXEC_FAIL_I,
	input  wire [1:0] EXEC_CODE_I,
	// command log in flash
	output wire       LOG_BEGIN_O,
	output wire       LOG_END_O,
	output wire       LOG_WR_VALID_O,
	input  wire       LOG_WR_READY_I,
	output wire [7:0] LOG_WR_DATA_O,
	output wire       LOG_RD_REQ_O,
	input  wire       LOG_RD_VALID_I,
	input  wire       LOG_RD_END_I,
	input  wire [7:0] LOG_RD_DATA_I,
	input  wire       LOG_OK_I,
	// target supply measurement
	input  wire [7:0] TARGET_MEAS_I,
	output wire [7:0] TARGET_SUPPLY_SETTING_O,
	output wire [7:0] ANALOG_REFERENCE_SETTING_O,
	// bi-colour indicator
	output wire       LED_GREEN_O,
	output wire       LED_RED_O
);

localparam [2:0] ST_NORMAL = 3'h0;
localparam [2:0] ST_REC    = 3'h1;
localparam [2:0] ST_RD     = 3'h2;
localparam [2:0] ST_EX     = 3'h3;
localparam [2:0] ST_RESULT = 3'h4;
localparam [2:0] ST_STATUS = 3'h5;

// states in which the host link is served
function host_mode;
	input [2:0] st;
	begin
		host_mode = (st == ST_NORMAL) || (st == ST_REC);
	end
endfunction

reg  [2:0]  st_q;
reg  [2:0]  st_d;
reg         exec_valid_q;
reg  [7:0]  exec_data_q;
reg         logw_valid_q;
reg  [7:0]  logw_data_q;
reg         rd_req_q;
reg         rsp_valid_q;
reg  [7:0]  rsp_data_q;
reg         begin_q;
reg         end_pend_q;
reg         end_q;
reg  [7:0]  meas_q;
reg         blink_start_q;
reg  [2:0]  blink_flash_q;
reg  [31:0] blink_dur_q;
reg         blink_red_q;
reg         led_g_q;
reg         led_r_q;
reg         led_g_d;
reg         led_r_d;

wire        short_ev;
wire        status_ev;
wire        long_ev;
wire        blink_led;
wire        blink_busy;

// idle engine and log writer before a new word is taken
wire host_rdy  = host_mode(st_q) && !exec_valid_q && !logw_valid_q;
wire host_take = HOST_CMD_VALID_I && host_rdy;
wire take_exec = host_take && (HOST_CMD_KIND_I == `ARC_KIND_EXEC);
wire leave_rec = (st_q == ST_REC) && (st_d != ST_REC);
wire enter_res = (st_d == ST_RESULT) && (st_q != ST_RESULT);
wire enter_sts = (st_d == ST_STATUS) && (st_q != ST_STATUS);

assign HOST_CMD_READY_O           = host_rdy;
assign HOST_RSP_VALID_O           = rsp_valid_q;
assign HOST_RSP_DATA_O            = rsp_data_q;
assign EXEC_VALID_O               = exec_valid_q;
assign EXEC_DATA_O                = exec_data_q;
assign LOG_BEGIN_O                = begin_q;
assign LOG_END_O                  = end_q;
assign LOG_WR_VALID_O             = logw_valid_q;
assign LOG_WR_DATA_O              = logw_data_q;
assign LOG_RD_REQ_O               = rd_req_q;
assign TARGET_SUPPLY_SETTING_O    = meas_q;
assign ANALOG_REFERENCE_SETTING_O = meas_q;
assign LED_GREEN_O                = led_g_q;
assign LED_RED_O                  = led_r_q;

arc_debounce #(
	.DEB_CYC   (DEB_CYC),
	.SHORT_CYC (SHORT_CYC),
	.LONG_CYC  (LONG_CYC)
) u_button (
	.clk_i      (CLK_I),
	.reset_n_i  (RESET_N_I),
	.button_n_i (BUTTON_N_I),
	.short_o    (short_ev),
	.status_o   (status_ev),
	.long_o     (long_ev)
);

arc_blink #(
	.HALF_CYC (HALF_CYC)
) u_blink (
	.clk_i     (CLK_I),
	.reset_n_i (RESET_N_I),
	.start_i   (blink_start_q),
	.flashes_i (blink_flash_q),
	.dur_i     (blink_dur_q),
	.led_o     (blink_led),
	.busy_o    (blink_busy)
);

// presses outside the host states are ignored
always @* begin
	st_d = st_q;
	case (st_q)
	ST_NORMAL: begin
		if (long_ev)
			st_d = ST_REC;
		else if (short_ev)
			st_d = LOG_OK_I ? ST_RD : ST_RESULT;
		else if (status_ev)
			st_d = ST_STATUS;
	end
	ST_REC: begin
		if (short_ev || status_ev)
			st_d = ST_NORMAL;
	end
	ST_RD: begin
		if (LOG_RD_END_I)
			st_d = ST_RESULT;
		else if (LOG_RD_VALID_I)
			st_d = ST_EX;
	end
	ST_EX: begin
		if (EXEC_DONE_I)
			st_d = EXEC_FAIL_I ? ST_RESULT : ST_RD;
	end
	ST_RESULT, ST_STATUS: begin
		if (!blink_busy && !blink_start_q)
			st_d = ST_NORMAL;
	end
	default: begin
		st_d = ST_NORMAL;
	end
	endcase
end

always @* begin
	led_g_d = 1'b0;
	led_r_d = 1'b0;
	case (st_q)
	ST_NORMAL: begin
		led_g_d = 1'b1;
	end
	ST_REC: begin
		led_r_d = 1'b1;
	end
	ST_RD, ST_EX: begin
		led_g_d = 1'b1;
		led_r_d = 1'b1;
	end
	ST_RESULT, ST_STATUS: begin
		led_g_d = blink_led & ~blink_red_q;
		led_r_d = blink_led & blink_red_q;
	end
	default: begin
		led_g_d = 1'b0;
		led_r_d = 1'b0;
	end
	endcase
end

always @(posedge CLK_I or negedge RESET_N_I) begin
	if (!RESET_N_I) begin
		st_q          <= ST_NORMAL;
		exec_valid_q  <= 1'b0;
		exec_data_q   <= `ARC_RST_BYTE;
		logw_valid_q  <= 1'b0;
		logw_data_q   <= `ARC_RST_BYTE;
		rd_req_q      <= 1'b0;
		rsp_valid_q   <= 1'b0;
		rsp_data_q    <= `ARC_RST_BYTE;
		begin_q       <= 1'b0;
		end_pend_q    <= 1'b0;
		end_q         <= 1'b0;
		meas_q        <= `ARC_RST_BYTE;
		blink_start_q <= 1'b0;
		blink_flash_q <= `ARC_FLASH_PLAIN;
		blink_dur_q   <= `ARC_RST_CNT;
		blink_red_q   <= 1'b0;
		led_g_q       <= 1'b0;
		led_r_q       <= 1'b0;
	end else begin
		st_q          <= st_d;
		led_g_q       <= led_g_d;
		led_r_q       <= led_r_d;
		rsp_valid_q   <= 1'b0;
		blink_start_q <= 1'b0;
		end_q         <= 1'b0;
		meas_q        <= TARGET_MEAS_I;
		// fetch one log word per step
		rd_req_q      <= (st_d == ST_RD) && (st_q != ST_RD);
		// a new hold restarts the log
		begin_q       <= long_ev && host_mode(st_q);

		// engine word from host or from the log
		if (take_exec) begin
			exec_valid_q <= 1'b1;
			exec_data_q  <= HOST_CMD_DATA_I;
		end else if (st_q == ST_RD && st_d == ST_EX) begin
			exec_valid_q <= 1'b1;
			exec_data_q  <= LOG_RD_DATA_I;
		end else if (EXEC_READY_I) begin
			exec_valid_q <= 1'b0;
		end

		if (take_exec && st_q == ST_REC) begin
			logw_valid_q <= 1'b1;
			logw_data_q  <= HOST_CMD_DATA_I;
		end else if (LOG_WR_READY_I) begin
			logw_valid_q <= 1'b0;
		end

		if (host_take && HOST_CMD_KIND_I != `ARC_KIND_EXEC) begin
			rsp_valid_q <= 1'b1;
			if (HOST_CMD_KIND_I == `ARC_KIND_READ_V)
				rsp_data_q <= meas_q;
			else
				rsp_data_q <= `ARC_RSP_OK;
		end

		// close log once last write drains
		if (leave_rec) begin
			end_pend_q <= 1'b1;
		end else if (end_pend_q && !logw_valid_q) begin
			end_pend_q <= 1'b0;
			end_q      <= 1'b1;
		end

		if (enter_res) begin
			blink_start_q <= 1'b1;
			blink_dur_q   <= RESULT_CYC;
			// bad or empty log is three flashes
			if (st_q == ST_NORMAL) begin
				blink_red_q   <= 1'b1;
				blink_flash_q <= `ARC_FLASH_LOG;
			// engine code picks one to four
			end else if (st_q == ST_EX) begin
				blink_red_q   <= 1'b1;
				blink_flash_q <= {1'b0, EXEC_CODE_I} + 3'h1;
			end else begin
				blink_red_q   <= 1'b0;
				blink_flash_q <= `ARC_FLASH_PLAIN;
			end
		end else if (enter_sts) begin
			blink_start_q <= 1'b1;
			blink_dur_q   <= STATUS_CYC;
			blink_red_q   <= ~LOG_OK_I;
			blink_flash_q <= `ARC_FLASH_PLAIN;
		end
	end
end

endmodule // arc_top

// [verification/arc_far.sv]
// engine and log flash model on the far side
`timescale 1ns/1ns
module arc_far (
	// clock, reset and scenario controls
	input  wire       clk_i, rst_n_i, slow_i,
	input  wire [7:0] fail_i,
	input  wire [1:0] code_i,
	// requests from the controller
	input  wire       ev_i, lb_i, le_i, lwv_i, lrq_i,
	input  wire [7:0] ed_i, lwd_i,
	// answers to the controller
	output reg        er_o, dn_o, fl_o, lwr_o, lrv_o, lre_o, ok_o,
	output reg  [1:0] ec_o,
	output wire [7:0] lrd_o
);
	reg [7:0] mem [0:15];
	reg [7:0] ex  [0:63];
	reg [7:0] rq;
	integer   wn, rn, en, tk;
	// released read bus shows the inverse, never stale data
	assign lrd_o = lrv_o ? rq : ~rq;
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{er_o, dn_o, fl_o, lwr_o, lrv_o, lre_o, ok_o} <= 7'h0;
			ec_o <= 2'h0;
			rq <= 8'h00;
			wn <= 0;
			rn <= 0;
			en <= 0;
			tk <= 0;
		end else begin
			tk <= tk + 1;
			// slow mode stalls the engine three cycles in four and the log writer every other cycle
			er_o <= !slow_i || tk % 4 == 3;
			lwr_o <= !slow_i || tk % 2 == 1;
			dn_o <= 1'b0;
			lrv_o <= 1'b0;
			lre_o <= 1'b0;
			if (ev_i && er_o) begin
				ex[en] <= ed_i;
				en <= en + 1;
				dn_o <= 1'b1;
				fl_o <= en == fail_i;
				ec_o <= code_i;
				if (en == fail_i)
					rn <= 0;
			end
			if (lwv_i && lwr_o) begin
				mem[wn] <= lwd_i;
				wn <= wn + 1;
			end
			if (lb_i) begin
				wn <= 0;
				ok_o <= 1'b0;
			end
			if (le_i)
				ok_o <= wn != 0;
			if (lrq_i && rn < wn) begin
				rq <= mem[rn];
				rn <= rn + 1;
				lrv_o <= 1'b1;
			end else if (lrq_i) begin
				lre_o <= 1'b1;
				rn <= 0;
			end
		end
	end
endmodule // arc_far

// [verification/arc_top_properties.sv]
// port checker of the replay controller
`timescale 1ns/1ns
module arc_props (
	input wire       CLK_I, RESET_N_I, HOST_CMD_VALID_I,
	input wire       HOST_CMD_READY_O, HOST_RSP_VALID_O, EXEC_VALID_O,
	input wire       EXEC_READY_I, LOG_WR_VALID_O, LOG_BEGIN_O,
	input wire       LED_GREEN_O, LED_RED_O,
	input wire [1:0] HOST_CMD_KIND_I,
	input wire [7:0] HOST_CMD_DATA_I, HOST_RSP_DATA_O, EXEC_DATA_O,
	input wire [7:0] LOG_WR_DATA_O, TARGET_MEAS_I,
	input wire [7:0] TARGET_SUPPLY_SETTING_O, ANALOG_REFERENCE_SETTING_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RESET_N_I);
	wire       tk = HOST_CMD_VALID_I && HOST_CMD_READY_O;
	wire [1:0] kd = HOST_CMD_KIND_I;
	wire       grn = LED_GREEN_O && !LED_RED_O;
	wire       red = LED_RED_O && !LED_GREEN_O;
	property p_rsp;
		tk && kd != 2'h0 |=> HOST_RSP_VALID_O;
	endproperty
	a_rsp: assert property (p_rsp) else $error("no answer");
	property p_inert;
		tk && (kd == 2'h1 || kd == 2'h2) |=> !EXEC_VALID_O && !LOG_WR_VALID_O;
	endproperty
	a_inert: assert property (p_inert) else $error("setting acted");
	property p_meas;
		tk && kd == 2'h3 && TARGET_SUPPLY_SETTING_O == TARGET_MEAS_I
			|=> HOST_RSP_DATA_O == $past(TARGET_MEAS_I);
	endproperty
	a_meas: assert property (p_meas) else $error("bad reading");
	property p_same;
		$past(RESET_N_I) |-> TARGET_SUPPLY_SETTING_O == $past(TARGET_MEAS_I)
			&& ANALOG_REFERENCE_SETTING_O == TARGET_SUPPLY_SETTING_O;
	endproperty
	a_same: assert property (p_same) else $error("settings differ");
	property p_exec;
		tk && kd == 2'h0 |=> EXEC_VALID_O
			&& EXEC_DATA_O == $past(HOST_CMD_DATA_I);
	endproperty
	a_exec: assert property (p_exec) else $error("word not passed");
	// lamp shows the state of the take cycle one edge later
	property p_log;
		tk && kd == 2'h0 ##1 red |-> LOG_WR_VALID_O
			&& LOG_WR_DATA_O == $past(HOST_CMD_DATA_I);
	endproperty
	a_log: assert property (p_log) else $error("word not logged");
	property p_nolog;
		tk && kd == 2'h0 ##1 grn |-> !LOG_WR_VALID_O;
	endproperty
	a_nolog: assert property (p_nolog) else $error("logged in normal");
	property p_hold;
		EXEC_VALID_O && !EXEC_READY_I |=> EXEC_VALID_O && $stable(EXEC_DATA_O);
	endproperty
	a_hold: assert property (p_hold) else $error("word dropped");
	property p_busy;
		LED_GREEN_O && LED_RED_O |-> !HOST_CMD_READY_O;
	endproperty
	a_busy: assert property (p_busy) else $error("host taken in replay");
	c_yellow: cover property (LED_GREEN_O && LED_RED_O);
	c_begin: cover property (LOG_BEGIN_O);
	c_read: cover property (tk && kd == 2'h3);
endmodule // arc_props
bind arc_top arc_props chk_u (.CLK_I, .RESET_N_I, .HOST_CMD_VALID_I,
	.HOST_CMD_READY_O, .HOST_RSP_VALID_O, .EXEC_VALID_O, .EXEC_READY_I,
	.LOG_WR_VALID_O, .LOG_BEGIN_O, .LED_GREEN_O, .LED_RED_O,
	.HOST_CMD_KIND_I, .HOST_CMD_DATA_I, .HOST_RSP_DATA_O, .EXEC_DATA_O,
	.LOG_WR_DATA_O, .TARGET_MEAS_I, .TARGET_SUPPLY_SETTING_O,
	.ANALOG_REFERENCE_SETTING_O);

// [verification/testbench.sv]
// self-checking bench of the replay controller
`timescale 1ns/1ns
module testbench;
	reg        clk, rst_n, btn_n, hv, slow;
	reg  [1:0] hk, code;
	reg  [7:0] hd, meas, fail_at;
	wire       hr, rv, ev, er, dn, fl, lb, le, lwv, lwr, lrq, lrv, lre;
	wire       ok, gr, rl;
	wire [1:0] ec;
	wire [7:0] rd, ed, lwd, lrd, ts, ar;
	integer    fail_count, checked, cyc, g_up, r_up, yel, nb, ne, i, c, base;
	arc_top #(.DEB_CYC(32'h4), .SHORT_CYC(32'h14), .LONG_CYC(32'h32),
		.HALF_CYC(32'h3), .RESULT_CYC(32'h3C), .STATUS_CYC(32'h28)) dut_u (
		.CLK_I(clk), .RESET_N_I(rst_n), .BUTTON_N_I(btn_n),
		.HOST_CMD_VALID_I(hv), .HOST_CMD_READY_O(hr), .HOST_CMD_KIND_I(hk),
		.HOST_CMD_DATA_I(hd), .HOST_RSP_VALID_O(rv), .HOST_RSP_DATA_O(rd),
		.EXEC_VALID_O(ev), .EXEC_READY_I(er), .EXEC_DATA_O(ed),
		.EXEC_DONE_I(dn), .EXEC_FAIL_I(fl), .EXEC_CODE_I(ec),
		.LOG_BEGIN_O(lb), .LOG_END_O(le), .LOG_WR_VALID_O(lwv),
		.LOG_WR_READY_I(lwr), .LOG_WR_DATA_O(lwd), .LOG_RD_REQ_O(lrq),
		.LOG_RD_VALID_I(lrv), .LOG_RD_END_I(lre), .LOG_RD_DATA_I(lrd),
		.LOG_OK_I(ok), .TARGET_MEAS_I(meas), .TARGET_SUPPLY_SETTING_O(ts),
		.ANALOG_REFERENCE_SETTING_O(ar), .LED_GREEN_O(gr), .LED_RED_O(rl));
	arc_far far_u (.clk_i(clk), .rst_n_i(rst_n), .slow_i(slow),
		.fail_i(fail_at), .code_i(code), .ev_i(ev), .lb_i(lb), .le_i(le),
		.lwv_i(lwv), .lrq_i(lrq), .ed_i(ed), .lwd_i(lwd), .er_o(er),
		.dn_o(dn), .fl_o(fl), .lwr_o(lwr), .lrv_o(lrv), .lre_o(lre),
		.ok_o(ok), .ec_o(ec), .lrd_o(lrd));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// pulse counters sample mid-cycle, away from the launching edge
	always @(negedge clk) begin
		if (lb) nb = nb + 1;
		if (le) ne = ne + 1;
	end
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 8000) begin
			fail_count = fail_count + 1;
			results;
		end
	end
	task tick(input integer n);
		begin
			repeat (n) @(posedge clk);
			#1;
		end
	endtask
	task check(input [31:0] seen, input [31:0] exp);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				fail_count = fail_count + 1;
				$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task host(input [1:0] k, input [7:0] d);
		integer n;
		begin
			hv = 1'b1;
			hk = k;
			hd = d;
			for (n = 0; n < 99 && hr !== 1'b1; n = n + 1)
				tick(1);
			tick(1);
		end
	endtask
	task idle;
		begin
			hv = 1'b0;
			tick(1);
		end
	endtask
	task press(input integer hold);
		begin
			tick(8);
			// a one-cycle bounce first, too short to count
			btn_n = 1'b0;
			tick(1);
			btn_n = 1'b1;
			tick(2);
			btn_n = 1'b0;
			tick(hold);
			btn_n = 1'b1;
			tick(1);
		end
	endtask
	task watch(input integer n);
		integer k;
		reg     pg, pr;
		begin
			g_up = 0;
			r_up = 0;
			yel = 0;
			pg = gr;
			pr = rl;
			for (k = 0; k < n; k = k + 1) begin
				tick(1);
				if (gr && rl) yel = yel + 1;
				if (gr && !pg && !rl) g_up = g_up + 1;
				if (rl && !pr && !gr) r_up = r_up + 1;
				pg = gr;
				pr = rl;
			end
		end
	endtask
	task waitred;
		integer n;
		begin
			for (n = 0; n < 300 && !(rl === 1'b1 && gr === 1'b0); n = n + 1)
				tick(1);
		end
	endtask
	task t_host;
		begin
			host(2'h1, 8'hA5);
			check({rv, rd}, {1'b1, 8'h00});
			host(2'h2, 8'h3C);
			check({rv, rd}, {1'b1, 8'h00});
			host(2'h3, 8'h00);
			check({rv, rd}, {1'b1, 8'h5A});
			// a new measurement must reach both readings
			meas = 8'hC3;
			idle;
			check({ts, ar, ev}, {16'hC3C3, 1'b0});
			host(2'h3, 8'h00);
			check({rv, rd}, {1'b1, 8'hC3});
			host(2'h0, 8'h11);
			check({ev, ed, lwv}, {1'b1, 8'h11, 1'b0});
			idle;
			$display("test host done");
		end
	endtask
	task t_record;
		begin
			slow = 1'b1;
			press(80);
			check(nb, 1);
			check({gr, rl}, 2'h1);
			for (i = 0; i < 3; i = i + 1) begin
				host(2'h0, 8'h21 + i[7:0]);
				check({lwv, lwd}, {1'b1, 8'h21 + i[7:0]});
				idle;
			end
			tick(20);
			check(far_u.wn, 3);
			press(10);
			tick(10);
			check(ne, 1);
			check({gr, rl}, 2'h2);
			host(2'h0, 8'h55);
			check(lwv, 0);
			idle;
			$display("test record done");
		end
	endtask
	task t_replay;
		begin
			// let the last host word drain in slow mode
			tick(8);
			base = far_u.en;
			press(10);
			watch(150);
			check(yel > 0, 1);
			check(g_up > 1, 1);
			check(r_up, 0);
			check(far_u.en - base, 3);
			for (i = 0; i < 3; i = i + 1)
				check(far_u.ex[base + i], 8'h21 + i[7:0]);
			check({gr, rl}, 2'h2);
			watch(20);
			check(g_up + r_up, 0);
			$display("test replay done");
		end
	endtask
	task t_fail;
		begin
			for (c = 0; c < 4; c = c + 1) begin
				fail_at = far_u.en[7:0];
				code = c[1:0];
				press(10);
				waitred;
				watch(6 * c + 11);
				check(r_up, c);
				check(g_up, 0);
				tick(80);
				check({gr, rl}, 2'h2);
			end
			fail_at = 8'hFF;
			$display("test fail done");
		end
	endtask
	task t_status;
		begin
			press(40);
			watch(30);
			check(yel, 0);
			check(g_up > 0, 1);
			check(r_up, 0);
			tick(30);
			press(80);
			press(10);
			tick(10);
			check(ok, 0);
			press(40);
			watch(30);
			check(g_up, 0);
			check(r_up > 0, 1);
			tick(30);
			// an empty log cannot replay
			press(10);
			waitred;
			watch(23);
			check(r_up, 2);
			tick(80);
			$display("test status done");
		end
	endtask
	task results;
		begin
			$display("checks %0d, mismatches %0d", checked, fail_count);
			if (fail_count == 0 && checked > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	initial begin
		{rst_n, hv, slow} = 3'h0;
		btn_n = 1'b1;
		hk = 2'h0;
		hd = 8'h00;
		code = 2'h0;
		meas = 8'h5A;
		fail_at = 8'hFF;
		{fail_count, checked, cyc, nb, ne} = 0;
		repeat (16) @(posedge clk);
		#1;
		rst_n = 1'b1;
		tick(1);
		t_host;
		t_record;
		t_replay;
		t_fail;
		t_status;
		results;
	end
endmodule // testbench
